// file: fwd_rev_pkg.sv
package fwd_rev_pkg;
    localparam int          NUM_INPUTS       = 8;
    localparam int          CODE_W           = 8;
    localparam int          VERSION_W        = 10;
    // Direction source codes
    localparam logic [7:0]  DIR_SRC_APP_CW   = 8'h09;
    localparam logic [7:0]  DIR_SRC_APP_CCW  = 8'h0a;
    // Run source code selecting the application
    localparam logic [7:0]  RUN_SRC_APP      = 8'h04;
    // Input function codes
    localparam logic [7:0]  FUNC_FORWARD     = 8'h14;
    localparam logic [7:0]  FUNC_REVERSE     = 8'h15;
    // Version in hundredths, 0.00 .. 10.00
    localparam logic [9:0]  VERSION_MAX      = 10'h3e8;
    localparam logic [9:0]  VERSION_DEFAULT  = 10'h064;
    // Direction encoding
    localparam logic        DIR_CW           = 1'b0;
    localparam logic        DIR_CCW          = 1'b1;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_FORWARD = 2'b01,
        ST_REVERSE = 2'b10
    } run_state_type;
endpackage

// file: input_sync.sv
module input_sync
    import fwd_rev_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_type;

    sync_state_type state_q;
    sync_state_type state_d;

    always_comb
    begin
        state_d      = state_q;
        state_d.meta = i_async;
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_sync = state_q.sync;
endmodule

// file: fwd_rev_run_input_logic.sv
// What this block does
// - Local run selects application, local direction not: raise alarm, stay disabled.
// - Remote run selects application, remote direction not: raise alarm, stay disabled.
// - Input whose function selector holds 20 is the forward input.
// - Input whose function selector holds 21 is the reverse input.
// - Several inputs with same code: lowest-numbered input wins.
// - No forward input configured: raise alarm, stay disabled.
// - No reverse input configured: raise alarm, stay disabled.
// - Forward means clockwise, reverse means counterclockwise, fixed.
// - Inputs active high (24 V), inactive low (0 V).
// - General enable needs mode enable, no fault, no undervoltage, no alarms.
// - With an enable input assigned, that input must also be active.
// - Forward alone runs forward; later reverse changes nothing.
// - Reverse alone runs reverse; later forward changes nothing.
// - Both inactive: run withdrawn, motor decelerates to zero.
// - Both becoming active together: forward wins.
// - Local mode with input 1 used may enter setup hold.
// - Read-only application version, 0.00 to 10.00.
module fwd_rev_run_input_logic
    import fwd_rev_pkg::*;
#(
    parameter int                   NUM_DI  = NUM_INPUTS,
    parameter logic [VERSION_W-1:0] VERSION = VERSION_DEFAULT
)
(
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_rstn,
    // Source selection configuration
    input  wire logic [fwd_rev_pkg::CODE_W-1:0]  i_local_direction_source_select,
    input  wire logic [fwd_rev_pkg::CODE_W-1:0]  i_local_run_source_select,
    input  wire logic [fwd_rev_pkg::CODE_W-1:0]  i_remote_direction_source_select,
    input  wire logic [fwd_rev_pkg::CODE_W-1:0]  i_remote_run_source_select,
    input  wire logic [NUM_DI*fwd_rev_pkg::CODE_W-1:0] i_input_function_selectors,
    // Mode and drive status
    input  wire logic                            i_remote_mode,
    input  wire logic                            i_mode_enabled,
    input  wire logic                            i_fault,
    input  wire logic                            i_undervoltage,
    input  wire logic                            i_enable_input_assigned,
    input  wire logic                            i_enable_input_active,
    // Digital input pins
    input  wire logic [NUM_DI-1:0]               i_digital_input_n,
    // Commands
    output logic                                 o_run,
    output logic                                 o_direction,
    output logic                                 o_general_enable,
    // Alarms and status
    output logic                                 o_missing_forward_input_alarm,
    output logic                                 o_missing_reverse_input_alarm,
    output logic                                 o_local_direction_source_alarm,
    output logic                                 o_remote_direction_source_alarm,
    output logic                                 o_setup_hold_state,
    output logic [fwd_rev_pkg::VERSION_W-1:0]    o_app_version
);
    import fwd_rev_pkg::*;

    typedef struct packed
    {
        run_state_type          run_state;
        logic                   run;
        logic                   direction;
        logic                   gen_enable;
        logic                   fwd_alarm;
        logic                   rev_alarm;
        logic                   loc_alarm;
        logic                   rem_alarm;
        logic                   setup_hold;
        logic [VERSION_W-1:0]   version;
    } ctrl_state_type;

    ctrl_state_type state_q;
    ctrl_state_type state_d;

    logic [NUM_DI-1:0] di_sync;

    // One synchronised sample of all inputs per cycle
    input_sync #(
        .WIDTH (NUM_DI)
    ) u_input_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (i_digital_input_n),
        .o_sync  (di_sync)
    );

    // Priority selection, input 1 first
    logic                   fwd_found;
    logic                   rev_found;
    logic                   fwd_level;
    logic                   rev_level;
    logic                   di1_used;
    logic [CODE_W-1:0]      sel_code;

    always_comb
    begin
        fwd_found = 1'b0;
        rev_found = 1'b0;
        fwd_level = 1'b0;
        rev_level = 1'b0;
        sel_code  = '0;
        for (int i = 0; i < NUM_DI; i++)
        begin
            sel_code = i_input_function_selectors[i*CODE_W +: CODE_W];
            if (!fwd_found && sel_code == FUNC_FORWARD)
            begin
                fwd_found = 1'b1;
                fwd_level = di_sync[i];
            end
            if (!rev_found && sel_code == FUNC_REVERSE)
            begin
                rev_found = 1'b1;
                rev_level = di_sync[i];
            end
        end
        di1_used = (i_input_function_selectors[CODE_W-1:0] == FUNC_FORWARD)
                || (i_input_function_selectors[CODE_W-1:0] == FUNC_REVERSE);
    end

    // Configuration checks
    logic loc_dir_ok;
    logic rem_dir_ok;
    logic loc_alarm;
    logic rem_alarm;
    logic any_alarm;
    logic enable_ok;

    always_comb
    begin
        loc_dir_ok = (i_local_direction_source_select == DIR_SRC_APP_CW)
                  || (i_local_direction_source_select == DIR_SRC_APP_CCW);
        rem_dir_ok = (i_remote_direction_source_select == DIR_SRC_APP_CW)
                  || (i_remote_direction_source_select == DIR_SRC_APP_CCW);
        loc_alarm  = (i_local_run_source_select == RUN_SRC_APP) && !loc_dir_ok;
        rem_alarm  = (i_remote_run_source_select == RUN_SRC_APP) && !rem_dir_ok;
        any_alarm  = !fwd_found || !rev_found || loc_alarm || rem_alarm;
        enable_ok  = i_mode_enabled && !i_fault && !i_undervoltage && !any_alarm;
        if (i_enable_input_assigned)
        begin
            enable_ok = enable_ok && i_enable_input_active;
        end
    end

    always_comb
    begin
        state_d            = state_q;
        state_d.fwd_alarm  = !fwd_found;
        state_d.rev_alarm  = !rev_found;
        state_d.loc_alarm  = loc_alarm;
        state_d.rem_alarm  = rem_alarm;
        state_d.gen_enable = enable_ok;
        state_d.setup_hold = !i_remote_mode && di1_used
                          && (i_local_run_source_select == RUN_SRC_APP);
        state_d.version    = (VERSION > VERSION_MAX) ? VERSION_MAX : VERSION;
        if (!enable_ok)
        begin
            state_d.run_state = ST_IDLE;
        end
        else
        begin
            case (state_q.run_state)
                ST_IDLE:
                begin
                    if (fwd_level)
                    begin
                        state_d.run_state = ST_FORWARD;
                    end
                    else if (rev_level)
                    begin
                        state_d.run_state = ST_REVERSE;
                    end
                end
                ST_FORWARD:
                begin
                    if (!fwd_level && !rev_level)
                    begin
                        state_d.run_state = ST_IDLE;
                    end
                end
                ST_REVERSE:
                begin
                    if (!fwd_level && !rev_level)
                    begin
                        state_d.run_state = ST_IDLE;
                    end
                end
                default:
                begin
                    state_d.run_state = ST_IDLE;
                end
            endcase
        end
        state_d.run = (state_d.run_state != ST_IDLE);
        if (state_d.run_state == ST_FORWARD)
        begin
            state_d.direction = DIR_CW;
        end
        else if (state_d.run_state == ST_REVERSE)
        begin
            state_d.direction = DIR_CCW;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q            <= '0;
            state_q.run_state  <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_run                           = state_q.run;
    assign o_direction                     = state_q.direction;
    assign o_general_enable                = state_q.gen_enable;
    assign o_missing_forward_input_alarm   = state_q.fwd_alarm;
    assign o_missing_reverse_input_alarm   = state_q.rev_alarm;
    assign o_local_direction_source_alarm  = state_q.loc_alarm;
    assign o_remote_direction_source_alarm = state_q.rem_alarm;
    assign o_setup_hold_state              = state_q.setup_hold;
    assign o_app_version                   = state_q.version;

    // Checks
    sequence fwd_alone_s;
        enable_ok && fwd_level && state_q.run_state == ST_IDLE;
    endsequence

    sequence rev_alone_s;
        enable_ok && !fwd_level && rev_level && state_q.run_state == ST_IDLE;
    endsequence

    chk_forward_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fwd_alone_s |=> o_run && o_direction == DIR_CW)
        else $error("forward start not issued");

    chk_reverse_start: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rev_alone_s |=> o_run && o_direction == DIR_CCW)
        else $error("reverse start not issued");

    chk_direction_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (o_run && enable_ok && (fwd_level || rev_level)) |=> $stable(o_direction) && o_run)
        else $error("direction changed while running");

    chk_release_stops: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!fwd_level && !rev_level) |=> !o_run)
        else $error("run not withdrawn");

    chk_fwd_missing: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !fwd_found |=> o_missing_forward_input_alarm && !o_general_enable && !o_run)
        else $error("missing forward not flagged");

    chk_rev_missing: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !rev_found |=> o_missing_reverse_input_alarm && !o_general_enable && !o_run)
        else $error("missing reverse not flagged");

    chk_local_alarm: assert property (@(posedge i_clk) disable iff (!i_rstn)
        loc_alarm |=> o_local_direction_source_alarm && !o_general_enable)
        else $error("local direction alarm missing");

    chk_remote_alarm: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rem_alarm |=> o_remote_direction_source_alarm && !o_general_enable)
        else $error("remote direction alarm missing");

    chk_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_fault || i_undervoltage || !i_mode_enabled
            || (i_enable_input_assigned && !i_enable_input_active)) |=> !o_general_enable)
        else $error("enable despite blocking condition");

    chk_version_range: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_app_version <= VERSION_MAX)
        else $error("version out of range");

    chk_setup_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_remote_mode |=> !o_setup_hold_state)
        else $error("setup hold in remote mode");
endmodule

// file: fwd_rev_contacts.sv
module fwd_rev_contacts
(
    // Clock
    input  wire logic       i_clk,
    // Requested contact states and timing
    input  wire logic [7:0] i_level,
    input  wire logic       i_slow,
    // Pins
    output logic      [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] late_q;
    always @(posedge i_clk)
    begin
        late_q <= i_level;
    end
    // Closed contact puts 24 V (high), open gives 0 V (low); slow contacts lag a cycle
    assign o_pin = i_slow ? late_q : i_level;
endmodule

// file: test_fwd_rev_run_input_logic.sv
module test_fwd_rev_run_input_logic import fwd_rev_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] ldir, lrun, rdir, rrun, level, prev, pins;
    logic [7:0] sel [8];
    logic [7:0] codes [4] = '{FUNC_FORWARD, FUNC_REVERSE, 8'h00, 8'h07};
    logic [63:0] sel_flat;
    logic       rmode, men, flt, uv, ea, eact, slow, dir_m;
    logic       run, dir, gen, a_fw, a_rv, a_ld, a_rd, hold;
    logic [9:0] ver;
    logic [31:0] lfsr = 32'h98cc627a;
    logic [31:0] r;
    run_state_type st;
    int         bad_count = 0;
    int         total_checks = 0;
    always #12.5 clk = ~clk;
    always_comb
    begin
        for (int i = 0; i < 8; i++) sel_flat[8*i+:8] = sel[i];
    end
    fwd_rev_contacts contacts (.i_clk(clk), .i_level(level), .i_slow(slow), .o_pin(pins));
    fwd_rev_run_input_logic #(.VERSION(10'h2a3)) DUT (
        .i_clk(clk), .i_rstn(rstn),
        .i_local_direction_source_select(ldir), .i_local_run_source_select(lrun),
        .i_remote_direction_source_select(rdir), .i_remote_run_source_select(rrun),
        .i_input_function_selectors(sel_flat), .i_remote_mode(rmode), .i_mode_enabled(men),
        .i_fault(flt), .i_undervoltage(uv), .i_enable_input_assigned(ea),
        .i_enable_input_active(eact), .i_digital_input_n(pins), .o_run(run), .o_direction(dir),
        .o_general_enable(gen), .o_missing_forward_input_alarm(a_fw),
        .o_missing_reverse_input_alarm(a_rv), .o_local_direction_source_alarm(a_ld),
        .o_remote_direction_source_alarm(a_rd), .o_setup_hold_state(hold), .o_app_version(ver));
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic int pick(logic [7:0] code);
        for (int i = 0; i < 8; i++) if (sel[i] === code) return i;
        return -1;
    endfunction
    function automatic logic [3:0] alarms_exp();
        logic ld;
        logic rd;
        ld = lrun == RUN_SRC_APP && !(ldir == DIR_SRC_APP_CW || ldir == DIR_SRC_APP_CCW);
        rd = rrun == RUN_SRC_APP && !(rdir == DIR_SRC_APP_CW || rdir == DIR_SRC_APP_CCW);
        return {rd, ld, pick(FUNC_REVERSE) < 0, pick(FUNC_FORWARD) < 0};
    endfunction
    function automatic logic en_exp();
        return men && !flt && !uv && alarms_exp() == 4'h0 && (!ea || eact);
    endfunction
    task automatic advance(logic [7:0] p);
        int f;
        int v;
        logic fa;
        logic ra;
        f = pick(FUNC_FORWARD);
        v = pick(FUNC_REVERSE);
        fa = f >= 0 && p[f];
        ra = v >= 0 && p[v];
        if (!en_exp()) st = ST_IDLE;
        else if (st == ST_IDLE)
        begin
            if (fa) begin st = ST_FORWARD; dir_m = DIR_CW; end
            else if (ra) begin st = ST_REVERSE; dir_m = DIR_CCW; end
        end
        else if (!fa && !ra) st = ST_IDLE;
    endtask
    task automatic check_bit(string what, logic got, logic exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic check_ver(logic [9:0] got, logic [9:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t version got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        logic [3:0] a;
        a = alarms_exp();
        check_bit("fwd alarm", a_fw, a[0]);
        check_bit("rev alarm", a_rv, a[1]);
        check_bit("local alarm", a_ld, a[2]);
        check_bit("remote alarm", a_rd, a[3]);
        check_bit("enable", gen, en_exp());
        check_bit("run", run, st != ST_IDLE);
        check_bit("direction", dir, dir_m);
        check_bit("setup hold", hold, !rmode && (sel[0] == FUNC_FORWARD || sel[0] == FUNC_REVERSE)
                  && lrun == RUN_SRC_APP);
        check_ver(ver, 10'h2a3);
    endtask
    task automatic sync();
        @(posedge clk);
        #2;
    endtask
    task automatic settle();
        advance(prev);
        advance(level);
        prev = level;
        repeat (6) @(posedge clk);
        #2;
        check_all();
    endtask
    task automatic set_pins(logic [7:0] l);
        sync();
        level = l;
        settle();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic base_cfg();
        sync();
        {ldir, lrun, rdir, rrun} = {DIR_SRC_APP_CW, RUN_SRC_APP, DIR_SRC_APP_CCW, RUN_SRC_APP};
        foreach (sel[i]) sel[i] = 8'h00;
        sel[2] = FUNC_FORWARD;
        sel[5] = FUNC_REVERSE;
        {rmode, men, flt, uv, ea, eact, slow} = 7'b1100000;
        settle();
    endtask
    initial
    begin
        {ldir, lrun, rdir, rrun, level, prev} = '0;
        foreach (sel[i]) sel[i] = 8'h00;
        {rmode, men, flt, uv, ea, eact, slow, dir_m} = '0;
        st = ST_IDLE;
        repeat (16) @(posedge clk);
        #2;
        check_bit("reset enable", gen, 1'b0);
        check_ver(ver, 10'h000);
        rstn = 1'b1;
        base_cfg();
        foreach (codes[k]) begin set_pins(8'h04); set_pins(8'h24); set_pins(8'h20); set_pins(8'h00); end
        set_pins(8'h20); set_pins(8'h24); set_pins(8'h00); set_pins(8'h24); set_pins(8'h00);
        $display("test direction done");
        sel[6] = FUNC_FORWARD;
        sel[7] = FUNC_REVERSE;
        set_pins(8'h40); set_pins(8'h80); set_pins(8'h04); set_pins(8'h00);
        sel[2] = 8'h00;
        set_pins(8'h40);
        sync(); sel[6] = 8'h00; settle();
        sync(); sel[2] = FUNC_FORWARD; sel[5] = 8'h00; sel[7] = 8'h00; settle();
        $display("test selection done");
        base_cfg();
        for (int k = 0; k < 8; k++)
        begin
            sync();
            {flt, uv, men, ea, eact} = {k == 1, k == 2, k != 3, k >= 4, k[0]};
            ldir = k == 5 ? 8'h00 : DIR_SRC_APP_CW;
            rdir = k == 6 ? 8'h03 : DIR_SRC_APP_CCW;
            level = 8'h04;
            settle();
            set_pins(8'h00);
        end
        sync(); rmode = 1'b0; sel[0] = FUNC_REVERSE; settle();
        $display("test enable done");
        for (int n = 0; n < 300; n++)
        begin
            sync();
            r = next_rand();
            if (r[31:29] == 3'h0)
            begin
                foreach (sel[i]) sel[i] = codes[r[2*i+:2]];
                r = next_rand();
                ldir = r[0] ? DIR_SRC_APP_CW : (r[1] ? DIR_SRC_APP_CCW : 8'h03);
                lrun = r[2] | r[3] ? RUN_SRC_APP : 8'h01;
                rdir = r[4] ? DIR_SRC_APP_CW : (r[5] ? DIR_SRC_APP_CCW : 8'h00);
                rrun = r[6] ? RUN_SRC_APP : 8'h02;
                {rmode, men, flt, uv} = {r[7], r[8] | r[9], r[10] & r[11], r[12] & r[13]};
                {ea, eact, slow} = {r[14], r[15] | r[16], r[17]};
            end
            level = r[25:18];
            settle();
        end
        $display("test random done");
        complete_run();
    end
    initial
    begin
        #(25 * 20000);
        bad_count++;
        complete_run();
    end
endmodule
